// [logic/fdc_dma.v]
// Four-channel DMA controller: arbitration, reload buffers, bus sequencer
`timescale 1ns/10ps
`default_nettype none
`include "fdc_consts.vh"

// Function
// - 16-bit across width mismatch: one wide access, two narrow back to back.
// - 8-bit across widths: one read, one write, upper lanes undriven.
// - Split writes: low byte first if little endian, high first if big.
// - Internal objects make no external cycle; ext I/O SRAM; memory programmed.
// - Fixed priority channel 0 highest, arbitration only in idle state.
// - Block transfer keeps its channel until the block finishes, an NMI is pending or its enable clears.
// - Single-step: higher priority request wins once bus returns idle.
// - Address and count are two-stage; active copy reloads at terminal count when a new count is staged.
// - Enabled multi-load channel restarts automatically after reload.
// - External requests of channels 0 and 1 sampled each edge as levels.
// - External request valid in idle with enable set, terminal flag clear.
// - Software trigger starts channel when enabled and terminal flag clear.
// - Selected peripheral interrupt starts enabled, non-terminated channel.
// - Terminal count pin pulses one clock at start of final write.
// - NMI clears all enables after the current transfer; then acknowledged.
// - After NMI, step and block keep pending request; single waits anew.
// - Abort bit clears that channel's enable and pending request; a running unit completes.
// - Acknowledge pin falls at least four clocks after request accepted.
// - Terminal flag set raises that channel's end-of-transfer interrupt.
// - Idle state issues no access; grant state holds bus for first access.
module fdc_dma (
    input  wire        ref_clk_i,      // Core clock, 100 MHz
    input  wire        nrst_i,         // Async reset, active low
    input  wire [7:0]  reg_addr_i,     // Register word address
    input  wire [15:0] reg_wdata_i,    // Register write data
    input  wire        reg_wr_i,       // Write strobe
    input  wire        reg_rd_i,       // Read strobe
    output reg  [15:0] reg_rdata_o,    // Read data, cycle after strobe
    input  wire [1:0]  ext_req_n_i,    // External request pins, ch 0/1
    input  wire [15:0] periph_irq_i,   // On-chip peripheral interrupts
    input  wire        nmi_i,          // Non-maskable interrupt level
    output reg         nmi_ack_o,      // NMI may now be serviced
    output reg  [1:0]  ack_n_o,        // Acknowledge pins, ch 0/1
    output reg         tc_n_o,         // Terminal count pin, active low
    output reg  [3:0]  end_irq_o,      // End-of-transfer interrupts
    output reg         bus_req_o,      // External bus cycle in progress
    output reg  [1:0]  bus_kind_o,     // Cycle kind: none/SRAM/programmed
    output reg         bus_wr_o,       // Write cycle when high
    output reg  [27:0] bus_addr_o,     // Access address
    output reg  [1:0]  bus_be_o,       // Byte lanes driven, [1] upper
    output reg  [15:0] bus_wdata_o,    // Write data
    output reg  [15:0] bus_wdata_oe_o, // Per-bit write data drive enable
    input  wire [15:0] bus_rdata_i,    // Read data
    input  wire        bus_done_i      // Access completes this cycle
);

    // ======================================================================
    // States
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_GRANT = 3'h1;
    localparam [2:0] ST_READ  = 3'h2;
    localparam [2:0] ST_GAP   = 3'h3;
    localparam [2:0] ST_WRITE = 3'h4;
    localparam [2:0] ST_END   = 3'h5;

    // ======================================================================
    // Per-channel storage indexed by channel: _act_q arrays active, _stg_q arrays staged
    reg [27:0] src_act_q [0:3];
    reg [27:0] dst_act_q [0:3];
    reg [15:0] cnt_act_q [0:3];
    reg [27:0] src_stg_q [0:3];
    reg [27:0] dst_stg_q [0:3];
    reg [15:0] cnt_stg_q [0:3];
    reg [3:0]  stg_new_q;
    reg [3:0]  en_q;
    reg [3:0]  tc_q;
    reg [3:0]  mle_q;
    reg [3:0]  stg_q;
    reg [3:0]  pend_q;
    reg [3:0]  trig_sel_q [0:3];
    reg [9:0]  mode_q [0:3];
    reg [1:0]  bus_type_q;
    reg [1:0]  req_s_q;
    reg [3:0]  periph_prev_q;

    reg [2:0]  state_q;
    reg [1:0]  ch_q;
    reg [1:0]  rd_cnt_q;
    reg [1:0]  wr_cnt_q;
    reg [15:0] data_q;
    reg [2:0]  wait_q;
    reg        nmi_pend_q;

    // ======================================================================
    // Request gathering, level-sensitive external pins
    wire [3:0] periph_hit;
    wire [3:0] ready;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ch
            assign periph_hit[g] = periph_irq_i[trig_sel_q[g]];
            // Only enabled, non-terminated channels may start
            assign ready[g] = en_q[g] & ~tc_q[g] & (pend_q[g] | stg_q[g]
                | (g < 2 ? req_s_q[g % 2] : 1'b0)
                | (periph_hit[g] & ~periph_prev_q[g]));
        end
    endgenerate

    // Fixed priority pick, lowest index first
    reg [1:0] win;
    always @* begin
        win = 2'h0;
        if (ready[0])      win = 2'h0;
        else if (ready[1]) win = 2'h1;
        else if (ready[2]) win = 2'h2;
        else               win = 2'h3;
    end

    // Current channel fields
    wire [9:0] cm      = mode_q[ch_q];
    wire       wide    = cm[2];
    wire       src8    = cm[3];
    wire       dst8    = cm[4];
    wire       big_end = cm[5];
    wire [1:0] rd_need = (wide & src8) ? 2'h2 : 2'h1;
    wire [1:0] wr_need = (wide & dst8) ? 2'h2 : 2'h1;
    wire       last    = (cnt_act_q[ch_q] == 16'h0001);

    // Cycle kind from object type
    function [1:0] kind;
        input [1:0] obj;
        input [1:0] bus_cycle_type_reg;
        begin
            if (obj == `FDC_OBJ_EXT_IO)       kind = `FDC_CYC_SRAM;
            else if (obj == `FDC_OBJ_EXT_MEM) kind = bus_cycle_type_reg;
            else                              kind = `FDC_CYC_NONE;
        end
    endfunction

    // ======================================================================
    // Register file, sequencer and pins in one clocked process
    integer i;
    wire [7:0] idx = reg_addr_i & 8'h07;
    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (i = 0; i < 4; i = i + 1) begin
                src_act_q[i] <= 28'h0;
                dst_act_q[i] <= 28'h0;
                cnt_act_q[i] <= 16'h0;
                src_stg_q[i] <= 28'h0;
                dst_stg_q[i] <= 28'h0;
                cnt_stg_q[i] <= 16'h0;
                trig_sel_q[i] <= 4'h0;
                mode_q[i] <= 10'h0;
            end
            stg_new_q <= 4'h0;
            en_q <= 4'h0;
            tc_q <= 4'h0;
            mle_q <= 4'h0;
            stg_q <= 4'h0;
            pend_q <= 4'h0;
            bus_type_q <= `FDC_CYC_PROG;
            req_s_q <= 2'h0;
            periph_prev_q <= 4'h0;
            state_q <= ST_IDLE;
            ch_q <= 2'h0;
            rd_cnt_q <= 2'h0;
            wr_cnt_q <= 2'h0;
            data_q <= 16'h0;
            wait_q <= 3'h0;
            nmi_pend_q <= 1'b0;
            nmi_ack_o <= 1'b0;
            ack_n_o <= 2'h3;
            tc_n_o <= 1'b1;
            end_irq_o <= 4'h0;
            bus_req_o <= 1'b0;
            bus_kind_o <= `FDC_CYC_NONE;
            bus_wr_o <= 1'b0;
            bus_addr_o <= 28'h0;
            bus_be_o <= 2'h0;
            bus_wdata_o <= 16'h0;
            bus_wdata_oe_o <= 16'h0;
            reg_rdata_o <= 16'h0;
        end else begin
            // Pin sampling each edge, level-detected
            req_s_q <= ~ext_req_n_i;
            for (i = 0; i < 4; i = i + 1)
                periph_prev_q[i] <= periph_hit[i];
            stg_q <= 4'h0;
            tc_n_o <= 1'b1;
            nmi_ack_o <= 1'b0;
            end_irq_o <= 4'h0;
            if (nmi_i)
                nmi_pend_q <= 1'b1;

            // Register read, one cycle later
            reg_rdata_o <= 16'h0;
            if (reg_rd_i) begin
                if (reg_addr_i == `FDC_OFF_BUS_TYPE)
                    reg_rdata_o <= {14'h0, bus_type_q};
                else if (reg_addr_i < 8'h20) begin
                    case (idx)
                    `FDC_OFF_SRC_HIGH: reg_rdata_o <=
                        {4'h0, src_act_q[reg_addr_i[4:3]][27:16]};
                    `FDC_OFF_SRC_LOW: reg_rdata_o <=
                        src_act_q[reg_addr_i[4:3]][15:0];
                    `FDC_OFF_DST_HIGH: reg_rdata_o <=
                        {4'h0, dst_act_q[reg_addr_i[4:3]][27:16]};
                    `FDC_OFF_DST_LOW: reg_rdata_o <=
                        dst_act_q[reg_addr_i[4:3]][15:0];
                    `FDC_OFF_COUNT: reg_rdata_o <=
                        cnt_act_q[reg_addr_i[4:3]];
                    `FDC_OFF_CTRL: reg_rdata_o <=
                        {12'h0, mle_q[reg_addr_i[4:3]], 1'b0,
                         tc_q[reg_addr_i[4:3]], en_q[reg_addr_i[4:3]]};
                    `FDC_OFF_TRIG_SEL: reg_rdata_o <=
                        {12'h0, trig_sel_q[reg_addr_i[4:3]]};
                    default: reg_rdata_o <=
                        {6'h0, mode_q[reg_addr_i[4:3]]};
                    endcase
                end
            end

            // Register write: address/count land in staging
            if (reg_wr_i && reg_addr_i == `FDC_OFF_BUS_TYPE)
                bus_type_q <= reg_wdata_i[1:0];
            else if (reg_wr_i && reg_addr_i < 8'h20) begin
                case (idx)
                `FDC_OFF_SRC_HIGH:
                    src_stg_q[reg_addr_i[4:3]][27:16] <= reg_wdata_i[11:0];
                `FDC_OFF_SRC_LOW:
                    src_stg_q[reg_addr_i[4:3]][15:0] <= reg_wdata_i;
                `FDC_OFF_DST_HIGH:
                    dst_stg_q[reg_addr_i[4:3]][27:16] <= reg_wdata_i[11:0];
                `FDC_OFF_DST_LOW:
                    dst_stg_q[reg_addr_i[4:3]][15:0] <= reg_wdata_i;
                `FDC_OFF_COUNT: begin
                    cnt_stg_q[reg_addr_i[4:3]] <= reg_wdata_i;
                    stg_new_q[reg_addr_i[4:3]] <= 1'b1;
                    // Channel not in service by the sequencer: load straight through
                    if (!(state_q != ST_IDLE && ch_q == reg_addr_i[4:3])) begin
                        src_act_q[reg_addr_i[4:3]] <=
                            src_stg_q[reg_addr_i[4:3]];
                        dst_act_q[reg_addr_i[4:3]] <=
                            dst_stg_q[reg_addr_i[4:3]];
                        cnt_act_q[reg_addr_i[4:3]] <= reg_wdata_i;
                        stg_new_q[reg_addr_i[4:3]] <= 1'b0;
                    end
                end
                `FDC_OFF_CTRL: begin
                    en_q[reg_addr_i[4:3]] <= reg_wdata_i[`FDC_CTL_EN];
                    mle_q[reg_addr_i[4:3]] <= reg_wdata_i[`FDC_CTL_MLE];
                    stg_q[reg_addr_i[4:3]] <= reg_wdata_i[`FDC_CTL_STG];
                    // Re-arm clears terminal flag
                    if (reg_wdata_i[`FDC_CTL_EN])
                        tc_q[reg_addr_i[4:3]] <= 1'b0;
                    // Abort drops pending work
                    if (reg_wdata_i[`FDC_CTL_ABORT]) begin
                        en_q[reg_addr_i[4:3]] <= 1'b0;
                        pend_q[reg_addr_i[4:3]] <= 1'b0;
                    end
                end
                `FDC_OFF_TRIG_SEL:
                    trig_sel_q[reg_addr_i[4:3]] <= reg_wdata_i[3:0];
                default:
                    mode_q[reg_addr_i[4:3]] <= reg_wdata_i[9:0];
                endcase
            end

            // Bus sequencer
            case (state_q)
            ST_IDLE: begin
                // No access issued here
                bus_req_o <= 1'b0;
                bus_be_o <= 2'h0;
                bus_wdata_oe_o <= 16'h0;
                if (nmi_pend_q) begin
                    // Suspend all; step/block keep pending
                    en_q <= 4'h0;
                    nmi_pend_q <= 1'b0;
                    nmi_ack_o <= 1'b1;
                end else if (|ready) begin
                    ch_q <= win;
                    if (mode_q[win][1:0] != `FDC_MODE_SINGLE)
                        pend_q[win] <= 1'b1;
                    wait_q <= `FDC_ACK_MIN_CLKS - 3'h1;
                    rd_cnt_q <= 2'h0;
                    wr_cnt_q <= 2'h0;
                    state_q <= ST_GRANT;
                end
            end
            ST_GRANT: begin
                // Acknowledge no sooner than four clocks
                if (wait_q == 3'h0) begin
                    if (ch_q < 2'h2 && cm[7:6] != `FDC_OBJ_IRAM)
                        ack_n_o[ch_q[0]] <= 1'b0;
                    state_q <= ST_READ;
                    bus_req_o <= (kind(cm[7:6], bus_type_q) != `FDC_CYC_NONE);
                    bus_kind_o <= kind(cm[7:6], bus_type_q);
                    bus_wr_o <= 1'b0;
                    bus_addr_o <= src_act_q[ch_q] + {27'h0, rd_cnt_q[0]};
                    bus_be_o <= (src8 | ~wide) ? 2'h1 : 2'h3;
                end else
                    wait_q <= wait_q - 3'h1;
            end
            ST_READ: begin
                if (bus_done_i) begin
                    // Narrow reads gather low then high byte
                    if (src8 && wide && rd_cnt_q[0])
                        data_q[15:8] <= bus_rdata_i[7:0];
                    else if (src8)
                        data_q <= {8'h0, bus_rdata_i[7:0]};
                    else
                        data_q <= bus_rdata_i;
                    if (rd_cnt_q + 2'h1 < rd_need) begin
                        rd_cnt_q <= rd_cnt_q + 2'h1;
                        bus_addr_o <= src_act_q[ch_q] + 28'h1;
                    end else begin
                        bus_req_o <= 1'b0;
                        bus_be_o <= 2'h0;
                        state_q <= ST_GAP;
                    end
                end
            end
            ST_GAP: begin
                // One idle clock between read and write
                state_q <= ST_WRITE;
                if (ch_q < 2'h2)
                    ack_n_o[ch_q[0]] <= (cm[9:8] == `FDC_OBJ_IRAM);
                bus_req_o <= (kind(cm[9:8], bus_type_q) != `FDC_CYC_NONE);
                bus_kind_o <= kind(cm[9:8], bus_type_q);
                bus_wr_o <= 1'b1;
                // Byte order by destination endianness
                bus_addr_o <= dst_act_q[ch_q]
                    + {27'h0, wide & dst8 & big_end};
                bus_be_o <= (dst8 | ~wide) ? 2'h1 : 2'h3;
                bus_wdata_oe_o <= (dst8 | ~wide) ? 16'h00ff : 16'hffff;
                bus_wdata_o <= (wide & dst8 & big_end)
                    ? {8'h0, data_q[15:8]} : data_q;
                if (last)
                    tc_n_o <= 1'b0;
            end
            ST_WRITE: begin
                if (bus_done_i) begin
                    if (wr_cnt_q + 2'h1 < wr_need) begin
                        // Second narrow write, back to back
                        wr_cnt_q <= wr_cnt_q + 2'h1;
                        bus_addr_o <= dst_act_q[ch_q]
                            + {27'h0, ~big_end};
                        bus_wdata_o <= big_end ? {8'h0, data_q[7:0]}
                                               : {8'h0, data_q[15:8]};
                    end else begin
                        bus_req_o <= 1'b0;
                        bus_be_o <= 2'h0;
                        bus_wdata_oe_o <= 16'h0;
                        ack_n_o <= 2'h3;
                        state_q <= ST_END;
                    end
                end
            end
            ST_END: begin
                src_act_q[ch_q] <= src_act_q[ch_q] + (wide ? 28'h2 : 28'h1);
                dst_act_q[ch_q] <= dst_act_q[ch_q] + (wide ? 28'h2 : 28'h1);
                cnt_act_q[ch_q] <= cnt_act_q[ch_q] - 16'h1;
                state_q <= ST_IDLE;
                if (last) begin
                    tc_q[ch_q] <= 1'b1;
                    end_irq_o[ch_q] <= 1'b1;
                    pend_q[ch_q] <= 1'b0;
                    if (stg_new_q[ch_q]) begin
                        // Reload from staging
                        src_act_q[ch_q] <= src_stg_q[ch_q];
                        dst_act_q[ch_q] <= dst_stg_q[ch_q];
                        cnt_act_q[ch_q] <= cnt_stg_q[ch_q];
                        // A count written this very clock stays staged
                        if (!(reg_wr_i && idx == `FDC_OFF_COUNT
                              && reg_addr_i[7:3] == {3'h0, ch_q}))
                            stg_new_q[ch_q] <= 1'b0;
                        if (en_q[ch_q] & mle_q[ch_q]) begin
                            tc_q[ch_q] <= 1'b0;
                            pend_q[ch_q] <= 1'b1;
                        end
                    end
                end else if (cm[1:0] == `FDC_MODE_BLOCK && !nmi_pend_q
                             && en_q[ch_q]) begin
                    // Block keeps the channel
                    wait_q <= 3'h0;
                    rd_cnt_q <= 2'h0;
                    wr_cnt_q <= 2'h0;
                    state_q <= ST_GRANT;
                end else if (cm[1:0] == `FDC_MODE_SINGLE)
                    pend_q[ch_q] <= 1'b0;
            end
            default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// [pkg/fdc_consts.vh]
// Offsets, field positions, mode and cycle codes and timing counts of the DMA block
`ifndef FDC_CONSTS_VH
`define FDC_CONSTS_VH

// ==========================================================================
// Register word offsets (per channel: base + 8*ch)
`define FDC_OFF_SRC_HIGH    8'h00
`define FDC_OFF_SRC_LOW     8'h01
`define FDC_OFF_DST_HIGH    8'h02
`define FDC_OFF_DST_LOW     8'h03
`define FDC_OFF_COUNT       8'h04
`define FDC_OFF_CTRL        8'h05
`define FDC_OFF_TRIG_SEL    8'h06
`define FDC_OFF_MODE        8'h07
`define FDC_OFF_BUS_TYPE    8'h20
`define FDC_CH_STRIDE       8'h08

// ==========================================================================
// Channel control fields
`define FDC_CTL_EN          0
`define FDC_CTL_TC          1
`define FDC_CTL_STG         2
`define FDC_CTL_MLE         3
`define FDC_CTL_ABORT       4

// ==========================================================================
// Mode register fields: [1:0] transfer mode, [2] 16-bit unit,
// [3] src 8-bit bus, [4] dst 8-bit bus, [5] dst big endian,
// [7:6] src object, [9:8] dst object
`define FDC_MODE_SINGLE     2'h0
`define FDC_MODE_STEP       2'h1
`define FDC_MODE_BLOCK      2'h2
`define FDC_OBJ_PERIPH      2'h0
`define FDC_OBJ_EXT_IO      2'h1
`define FDC_OBJ_IRAM        2'h2
`define FDC_OBJ_EXT_MEM     2'h3

// ==========================================================================
// Bus cycle kinds on the external bus
`define FDC_CYC_NONE        2'h0
`define FDC_CYC_SRAM        2'h1
`define FDC_CYC_PROG        2'h2

// ==========================================================================
// Timing: request acknowledge to acknowledge pin, in clocks
`define FDC_ACK_MIN_CLKS    3'h4
`define FDC_IRAM_MIN_CLKS   3'h1

`endif

// [verification/fdc_dma_properties.sv]
// Pin timing checker for the four-channel DMA block
`timescale 1ns/10ps
`default_nettype none
module fdc_dma_properties (
    input wire logic       ref_clk_i,   // Core clock
    input wire logic       nrst_i,      // Reset, active low
    input wire logic [1:0] ext_req_n_i, // Request pins
    input wire logic       bus_done_i,  // Access ends
    input wire logic       nmi_ack_o,   // NMI may be served
    input wire logic [1:0] ack_n_o,     // Acknowledge pins
    input wire logic       tc_n_o,      // Terminal count pin
    input wire logic [3:0] end_irq_o,   // End interrupts
    input wire logic       bus_req_o,   // Access running
    input wire logic       bus_wr_o     // Write access
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // ====================================================================
    // Terminal pulse: low one clock, then back high
    sequence s_tc_pulse;
        !tc_n_o ##1 tc_n_o;
    endsequence
    a_tc_one_clk: assert property ($fell(tc_n_o) |-> s_tc_pulse)
        else $error("terminal pulse not one clock");
    // Pulse shows as the write starts, two clocks after the last read ended
    a_tc_at_write: assert property ($fell(tc_n_o) |->
        $past(bus_done_i, 2) && !$past(bus_wr_o) && bus_wr_o)
        else $error("terminal pulse not at start of final write");
    // A request seen with the pin idle keeps it idle four more samples
    a_ack_delay: assert property (
        $fell(ext_req_n_i[0]) && ack_n_o[0] |-> ack_n_o[0] [*5])
        else $error("acknowledge fell too early");
    a_one_ack: assert property (ack_n_o != 2'b00)
        else $error("two channels acknowledged");
    a_irq_pulse: assert property (end_irq_o != 4'h0 |=>
        end_irq_o == 4'h0)
        else $error("end interrupt wider than one clock");
    // NMI is only let through once the bus is free
    a_nmi_idle: assert property (nmi_ack_o |->
        !bus_req_o ##1 !nmi_ack_o)
        else $error("NMI acknowledged during an access");
    a_nmi_quiet: assert property ($rose(nmi_ack_o) |=>
        (ack_n_o == 2'b11)[*3])
        else $error("transfer started after NMI");
    a_bus_hold: assert property (bus_req_o && !bus_done_i |=>
        bus_req_o && $stable(bus_wr_o))
        else $error("access dropped before done");
endmodule
bind fdc_dma fdc_dma_properties fdc_dma_properties_i (.ref_clk_i, .nrst_i,
    .ext_req_n_i, .bus_done_i, .nmi_ack_o, .ack_n_o, .tc_n_o, .end_irq_o,
    .bus_req_o, .bus_wr_o);
`default_nettype wire

// [verification/fdc_ext_model.sv]
// External requesters and memory seen by the DMA block
`timescale 1ns/10ps
`default_nettype none
module fdc_ext_model (
    input  wire logic        ref_clk_i,   // Clock
    input  wire logic        nrst_i,      // Reset, active low
    input  wire logic [1:0]  go_i,        // Raise request ch 0/1
    input  wire logic [1:0]  slow_i,      // Wait clocks per access
    input  wire logic [1:0]  ack_n_i,     // Acknowledge pins
    input  wire logic        bus_req_i,   // Access running
    input  wire logic        bus_wr_i,    // Write access
    input  wire logic [27:0] bus_addr_i,  // Address
    input  wire logic [1:0]  bus_be_i,    // Lanes written
    input  wire logic [15:0] bus_wdata_i, // Write data
    output logic      [1:0]  req_n_o,     // Request pins
    output logic      [15:0] rdata_o,     // Read data
    output logic             done_o       // Access ends
);
    // ====================================================================
    // Responder
    logic [1:0] wait_q;
    logic [7:0] log_q [$]; // Bytes written, oldest first
    // Off a read the lines show the inverse, never stale data
    assign rdata_o = bus_addr_i[15:0] ^
        (bus_req_i && !bus_wr_i ? 16'ha55a : 16'h5aa5);
    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            req_n_o <= 2'b11;
            wait_q <= 2'h0;
            done_o <= 1'b0;
        end else begin
            req_n_o <= (req_n_o & ~go_i) | ~ack_n_i;
            done_o <= bus_req_i && !done_o && wait_q == slow_i;
            wait_q <= (bus_req_i && !done_o && wait_q != slow_i) ?
                wait_q + 2'h1 : 2'h0;
            if (done_o && bus_wr_i && bus_be_i[0])
                log_q.push_back(bus_wdata_i[7:0]);
            if (done_o && bus_wr_i && bus_be_i[1])
                log_q.push_back(bus_wdata_i[15:8]);
        end
    end
endmodule
`default_nettype wire

// [verification/four_channel_dma_channel_control_test.sv]
// Directed bench of the four-channel DMA block
`timescale 1ns/10ps
`default_nettype none
`include "fdc_consts.vh"
module four_channel_dma_channel_control_test;
    logic ref_clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic nmi_i = 1'b0, nmi_ack_o, tc_n_o, bus_req_o, bus_done_i, bus_wr_o;
    logic [7:0] reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0, periph_irq_i = 16'h0, rd_v;
    logic [15:0] reg_rdata_o, bus_rdata_i, bus_wdata_o, bus_wdata_oe_o;
    logic [1:0] ext_req_n_i, ack_n_o, bus_kind_o, bus_be_o;
    logic [1:0] go = 2'h0, slow = 2'h0;
    logic [3:0] end_irq_o;
    logic [27:0] bus_addr_o;
    logic [15:0] modes [3] = '{16'h03d4, 16'h03f4, 16'h03d0};
    int bad_count = 0, checked = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    fdc_dma fdc_dma_i (.ref_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ext_req_n_i, .periph_irq_i,
        .nmi_i, .nmi_ack_o, .ack_n_o, .tc_n_o, .end_irq_o, .bus_req_o,
        .bus_kind_o, .bus_wr_o, .bus_addr_o, .bus_be_o, .bus_wdata_o,
        .bus_wdata_oe_o, .bus_rdata_i, .bus_done_i);
    fdc_ext_model fdc_ext_model_i (.ref_clk_i, .nrst_i, .go_i(go),
        .slow_i(slow), .ack_n_i(ack_n_o), .bus_req_i(bus_req_o),
        .bus_wr_i(bus_wr_o), .bus_addr_i(bus_addr_o), .bus_be_i(bus_be_o),
        .bus_wdata_i(bus_wdata_o), .req_n_o(ext_req_n_i),
        .rdata_o(bus_rdata_i), .done_o(bus_done_i));
    // ====================================================================
    // Verdict, compare and register bus tasks
    task automatic complete_run();
        $display("Mismatches %0d of %0d checks", bad_count, checked);
        if (bad_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 rd_v = reg_rdata_o;
        @(posedge ref_clk_i);
    endtask
    // Addresses go before the count, which loads the active copy;
    // low addresses, never internal RAM at both ends
    task automatic prog(input logic [7:0] b, input logic [15:0] m, c);
        wr(b + `FDC_OFF_SRC_HIGH, 16'h0000);
        wr(b + `FDC_OFF_SRC_LOW, 16'h0100);
        wr(b + `FDC_OFF_DST_HIGH, 16'h0000);
        wr(b + `FDC_OFF_DST_LOW, 16'h0200);
        wr(b + `FDC_OFF_MODE, m);
        wr(b + `FDC_OFF_COUNT, 16'h0001);
        wr(b + `FDC_OFF_CTRL, c);
    endtask
    // Bounded wait: 0-3 end interrupt, 4 any acknowledge, 5 NMI
    task automatic wait_on(input int k);
        int n;
        for (n = 0; n < 300; n++) begin
            @(posedge ref_clk_i);
            #1;
            if (k < 4 ? end_irq_o[k] === 1'b1 : k == 4 ?
                ack_n_o !== 2'b11 : nmi_ack_o === 1'b1)
                break;
        end
        if (n == 300) begin
            bad_count++;
            $display("CHECK FAILED %0t wait %0d ran out", $time, k);
            complete_run();
        end
    endtask
    // ====================================================================
    // Scenarios
    initial begin
        repeat (5) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        @(posedge ref_clk_i);
        rd(`FDC_OFF_BUS_TYPE);
        chk(rd_v, 16'h0002);
        rd(8'h21);
        chk(rd_v, 16'h0000);
        // Narrow destination: both endians, then a one-byte unit
        for (int e = 0; e < 3; e++) begin
            slow <= e[1:0];
            fdc_ext_model_i.log_q.delete();
            prog(8'h10, modes[e], 16'h0005);
            wait_on(2);
            chk(16'(fdc_ext_model_i.log_q.size()),
                e == 2 ? 16'h1 : 16'h2);
            chk({8'h0, fdc_ext_model_i.log_q[0]},
                e == 1 ? 16'ha4 : 16'h5a);
            rd(8'h10 + `FDC_OFF_CTRL);
            chk(rd_v & 16'h0002, 16'h0002);
        end
        // Both request pins together: channel 0 must win
        prog(8'h00, 16'h03c4, 16'h0001);
        prog(8'h08, 16'h03c4, 16'h0001);
        go <= 2'b11;
        @(posedge ref_clk_i);
        go <= 2'b00;
        wait_on(4);
        chk({14'h0, ack_n_o}, 16'h0002);
        chk({14'h0, bus_kind_o}, 16'h0002);
        wait_on(1);
        wr(8'h08 + `FDC_OFF_TRIG_SEL, 16'h0003);
        prog(8'h08, 16'h03c4, 16'h0001);
        periph_irq_i <= 16'h0008;
        wait_on(1);
        // Block unit started by software, NMI raised while it runs
        prog(8'h00, 16'h03c6, 16'h0005);
        nmi_i <= 1'b1;
        wait_on(5);
        nmi_i <= 1'b0;
        rd(`FDC_OFF_CTRL);
        chk(rd_v & 16'h0003, 16'h0002);
        complete_run();
    end
endmodule
`default_nettype wire
